// [shared/hls_pkg.sv]
// package for the health log sector builder: layout offsets, codes, types
// assumes a single 50 MHz clock domain for everything that uses it
package hls_pkg;
  localparam int          CLK_MHZ     = 50;
  localparam logic [7:0]  OP_HEALTH   = 8'hB0;
  localparam logic [7:0]  FEAT_STATUS = 8'hDA;
  localparam logic [7:0]  CYL_LO_OK   = 8'h4F;
  localparam logic [7:0]  CYL_HI_OK   = 8'hC2;
  localparam logic [7:0]  CYL_LO_BAD  = 8'hF4;
  localparam logic [7:0]  CYL_HI_BAD  = 8'h2C;
  localparam logic [7:0]  ERR_VER     = 8'h01;
  localparam logic [15:0] ST_REV      = 16'h0001;
  localparam logic [3:0]  STATE_HI    = 4'h0;
  localparam int          ERR_SLOTS   = 5;
  localparam int          ST_SLOTS    = 21;
  localparam logic [9:0]  ERR_BASE    = 10'h002;
  localparam logic [9:0]  ERR_LEN     = 10'h05A;
  localparam logic [9:0]  ERR_DATA    = 10'h03C;
  localparam logic [8:0]  ERR_CNT_LO  = 9'h1C4;
  localparam logic [9:0]  ST_LEN      = 10'h018;
  localparam logic [8:0]  ST_IDX_OFS  = 9'h1FC;
  localparam logic [8:0]  ST_END      = 9'h1F9;
  localparam logic [8:0]  SUM_OFS     = 9'h1FF;
  localparam logic [8:0]  LAST_SUMMED = 9'h1FE;
  localparam logic [15:0] CNT_MAX     = 16'hFFFF;

  typedef enum logic {SC_IDLE, SC_RUN} hls_scan_t;

  typedef struct packed {
    logic             hw_reset;
    logic [6:0][7:0]  regs;
    logic [7:0]       state;
    logic [15:0]      hours;
  } hls_err_t;

  typedef struct packed {
    logic [7:0]  sector;
    logic [7:0]  status;
    logic [15:0] hours;
    logic [7:0]  checkpoint;
    logic [31:0] lba;
  } hls_st_t;
endpackage : hls_pkg

// [logic/hls_builder.sv]
// health log sector builder: error log and self-test log sectors, plus
// the return-status command decode of the task-file command port
// assumes all inputs come from logic on the same clock; event inputs are
// one-cycle pulses
`timescale 1ns/10ps
`default_nettype none
module hls_builder
  import hls_pkg::*;
(
  // clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_n,
  // error event from the command engine
  input  wire logic        i_err_log,
  input  wire logic        i_err_device_caused,
  input  wire logic        i_err_hw_reset,
  input  wire logic [55:0] i_err_taskfile,
  input  wire logic [3:0]  i_err_state,
  input  wire logic [15:0] i_hours,
  // self-test events
  input  wire logic        i_st_issue,
  input  wire logic [7:0]  i_st_sector,
  input  wire logic        i_st_done,
  input  wire logic [7:0]  i_st_status,
  input  wire logic [7:0]  i_st_checkpoint,
  input  wire logic [31:0] i_st_lba,
  // sector read port
  input  wire logic        i_rd_req,
  input  wire logic        i_rd_sel,
  input  wire logic [8:0]  i_rd_addr,
  output logic             o_rd_valid,
  output logic [7:0]       o_rd_data,
  output logic             o_sum_busy,
  // task-file command write
  input  wire logic        i_cmd_wr,
  input  wire logic [7:0]  i_command,
  input  wire logic [7:0]  i_features,
  input  wire logic [7:0]  i_cyl_low,
  input  wire logic [7:0]  i_cyl_high,
  input  wire logic        i_device_select_bit,
  input  wire logic        i_own_device,
  input  wire logic        i_health_enabled,
  input  wire logic        i_packet_set,
  input  wire logic        i_threshold_exceeded,
  // return-status completion
  output logic             o_rs_done,
  output logic             o_command_abort_flag,
  output logic [7:0]       o_cyl_low,
  output logic [7:0]       o_cyl_high
);

  typedef struct packed {
    hls_err_t [ERR_SLOTS-1:0] err;
    logic [2:0]               err_idx;
    logic [2:0]               err_fill;
    logic [15:0]              err_cnt;
    hls_st_t [ST_SLOTS-1:0]   st;
    logic [4:0]               st_idx;
    logic [4:0]               st_fill;
    logic [7:0]               st_sec;
    hls_scan_t                scan;
    logic [9:0]               pos;
    logic [7:0]               sum;
    logic [7:0]               cks_err;
    logic [7:0]               cks_st;
    logic                     rd_valid;
    logic [7:0]               rd_data;
    logic                     rs_done;
    logic                     rs_abort;
    logic [7:0]               cyl_lo;
    logic [7:0]               cyl_hi;
  } hls_state_t;

  hls_state_t r;
  hls_state_t next_r;

  // one byte of either sector; byte 511 returns the last finished checksum
  function automatic logic [7:0] byte_at(hls_state_t s, logic sel, logic [8:0] a);
    logic [9:0] t;
    logic [9:0] k;
    logic [9:0] o;
    logic [7:0] b;
    hls_err_t   e;
    hls_st_t    d;
    b = 8'h00;
    if (!sel) begin
      t = {1'b0, a} - ERR_BASE;
      k = t / ERR_LEN;
      o = t - k * ERR_LEN;
      e = s.err[k[2:0]];
      if (a == 9'h000) b = ERR_VER;
      else if (a == 9'h001) b = {5'h00, s.err_idx};
      else if (a == ERR_CNT_LO) b = s.err_cnt[7:0];
      else if (a == ERR_CNT_LO + 9'h001) b = s.err_cnt[15:8];
      else if (a == SUM_OFS) b = s.cks_err;
      else if (a < ERR_CNT_LO && {7'h00, k[2:0]} < {7'h00, s.err_fill}) begin
        if (o > ERR_DATA && o <= ERR_DATA + 10'h007 && !e.hw_reset) begin
          b = e.regs[o - ERR_DATA - 10'h001];
        end else if (o == ERR_DATA + 10'h01B) begin
          b = e.state;
        end else if (o == ERR_DATA + 10'h01C) begin
          b = e.hours[7:0];
        end else if (o == ERR_DATA + 10'h01D) begin
          b = e.hours[15:8];
        end
        // command history and extended area stay zero
      end
    end else begin
      t = {1'b0, a} - ERR_BASE;
      k = t / ST_LEN;
      o = t - k * ST_LEN;
      d = s.st[k[4:0]];
      if (a == 9'h000) b = ST_REV[7:0];
      else if (a == 9'h001) b = ST_REV[15:8];
      else if (a == ST_IDX_OFS) b = {3'h0, s.st_idx};
      else if (a == SUM_OFS) b = s.cks_st;
      else if (a > 9'h001 && a <= ST_END && k[4:0] < s.st_fill) begin
        case (o)
          10'h000: b = d.sector;
          10'h001: b = d.status;
          10'h002: b = d.hours[7:0];
          10'h003: b = d.hours[15:8];
          10'h004: b = d.checkpoint;
          10'h005: b = d.lba[7:0];
          10'h006: b = d.lba[15:8];
          10'h007: b = d.lba[23:16];
          10'h008: b = d.lba[31:24];
          default: b = 8'h00;
        endcase
      end
    end
    return b;
  endfunction : byte_at

  logic       log_dev;
  logic       rs_hit;
  logic       rs_bad;
  logic [7:0] scan_byte;

  assign log_dev = i_err_log & i_err_device_caused;
  // other B0h subcommands belong to other engines and are not answered here
  assign rs_hit  = i_cmd_wr && i_command == OP_HEALTH && i_features == FEAT_STATUS
                   && i_device_select_bit == i_own_device;
  assign rs_bad  = !i_health_enabled || i_packet_set || i_cyl_low != CYL_LO_OK
                   || i_cyl_high != CYL_HI_OK;
  assign scan_byte = byte_at(r, r.pos[9], r.pos[8:0]);

  always_comb begin
    next_r = r;
    next_r.rd_valid = i_rd_req;
    if (i_rd_req) next_r.rd_data = byte_at(r, i_rd_sel, i_rd_addr);
    next_r.rs_done = rs_hit;
    if (rs_hit) begin
      next_r.rs_abort = rs_bad;
      if (!rs_bad) begin
        next_r.cyl_lo = i_threshold_exceeded ? CYL_LO_BAD : CYL_LO_OK;
        next_r.cyl_hi = i_threshold_exceeded ? CYL_HI_BAD : CYL_HI_OK;
      end
    end
    // checksum walk over bytes 0..510 of the error sector, then the self-test one
    if (r.scan == SC_RUN) begin
      next_r.sum = r.sum + scan_byte;
      next_r.pos = r.pos + 10'h001;
      if (r.pos[8:0] == LAST_SUMMED) begin
        next_r.sum = 8'h00;
        if (!r.pos[9]) begin
          next_r.cks_err = 8'h00 - (r.sum + scan_byte);
          next_r.pos = 10'h200;
        end else begin
          next_r.cks_st = 8'h00 - (r.sum + scan_byte);
          next_r.scan = SC_IDLE;
        end
      end
    end
    if (i_st_issue) next_r.st_sec = i_st_sector;
    if (log_dev) begin
      next_r.err_idx = (r.err_idx == 3'(ERR_SLOTS)) ? 3'h1 : r.err_idx + 3'h1;
      if (r.err_fill != 3'(ERR_SLOTS)) next_r.err_fill = r.err_fill + 3'h1;
      if (r.err_cnt != CNT_MAX) next_r.err_cnt = r.err_cnt + 16'h0001;
      next_r.err[next_r.err_idx - 3'h1] = '{hw_reset: i_err_hw_reset,
                                            regs:     i_err_taskfile,
                                            state:    {STATE_HI, i_err_state},
                                            hours:    i_hours};
    end
    if (i_st_done) begin
      next_r.st_idx = (r.st_idx == 5'(ST_SLOTS)) ? 5'h01 : r.st_idx + 5'h01;
      if (r.st_fill != 5'(ST_SLOTS)) next_r.st_fill = r.st_fill + 5'h01;
      next_r.st[next_r.st_idx - 5'h01] = '{sector:     r.st_sec,
                                           status:     i_st_status,
                                           hours:      i_hours,
                                           checkpoint: i_st_checkpoint,
                                           lba:        i_st_lba};
    end
    // any change to either sector restarts the walk; byte 511 stays stale until done
    if (log_dev || i_st_done) begin
      next_r.scan = SC_RUN;
      next_r.pos = 10'h000;
      next_r.sum = 8'h00;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      r <= '0;
      r.cks_err <= 8'h00 - ERR_VER;
      r.cks_st <= 8'h00 - ST_REV[7:0];
      r.cyl_lo <= CYL_LO_OK;
      r.cyl_hi <= CYL_HI_OK;
    end else begin
      r <= next_r;
    end
  end

  assign o_rd_valid           = r.rd_valid;
  assign o_rd_data            = r.rd_data;
  assign o_sum_busy           = (r.scan == SC_RUN);
  assign o_rs_done            = r.rs_done;
  assign o_command_abort_flag = r.rs_abort;
  assign o_cyl_low            = r.cyl_lo;
  assign o_cyl_high           = r.cyl_hi;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);

  // error log and lifetime count
  a_cnt_saturate: assert property (
    log_dev && r.err_cnt == CNT_MAX |=> r.err_cnt == CNT_MAX)
    else $error("error count wrapped");
  a_cnt_step: assert property (
    log_dev && r.err_cnt != CNT_MAX |=> r.err_cnt == $past(r.err_cnt) + 16'h0001)
    else $error("error count did not step");
  a_cnt_nondev: assert property (
    i_err_log && !i_err_device_caused |=> $stable(r.err_cnt))
    else $error("non-device error counted");
  a_cnt_hold: assert property (
    !log_dev |=> $stable(r.err_cnt))
    else $error("error count moved without an error");
  a_err_nondev_idx: assert property (
    i_err_log && !i_err_device_caused |=> $stable(r.err_idx))
    else $error("non-device error logged");
  a_err_idx_range: assert property (
    r.err_idx <= 3'h5)
    else $error("error index out of range");
  a_err_fill_max: assert property (
    r.err_fill <= 3'h5)
    else $error("error fill out of range");

  // self-test log
  a_st_wrap: assert property (
    i_st_done && r.st_idx == 5'h15 |=> r.st_idx == 5'h01)
    else $error("self-test index did not wrap to one");
  a_st_empty: assert property (
    (r.st_idx == 5'h00) == (r.st_fill == 5'h00))
    else $error("self-test index and fill disagree");
  a_st_step: assert property (
    i_st_done && r.st_idx != 5'h15 |=> r.st_idx == $past(r.st_idx) + 5'h01)
    else $error("self-test index did not step");
  a_st_hold: assert property (
    !i_st_done |=> $stable(r.st_idx))
    else $error("self-test index moved without a result");
  a_st_idx_range: assert property (
    r.st_idx <= 5'h15)
    else $error("self-test index out of range");
  a_st_fill_max: assert property (
    r.st_fill <= 5'h15)
    else $error("self-test fill out of range");
  a_st_fill_step: assert property (
    i_st_done && r.st_fill != 5'h15 |=> r.st_fill == $past(r.st_fill) + 5'h01)
    else $error("self-test fill did not step");
  a_rev_read: assert property (
    i_rd_req && i_rd_sel && i_rd_addr == 9'h000 |=> o_rd_valid && o_rd_data == 8'h01)
    else $error("self-test revision wrong");
  a_rev_high: assert property (
    i_rd_req && i_rd_sel && i_rd_addr == 9'h001 |=> o_rd_valid && o_rd_data == 8'h00)
    else $error("self-test revision high byte wrong");

  // checksum walk
  a_walk_start: assert property (
    log_dev || i_st_done |=> o_sum_busy)
    else $error("checksum walk did not start");
  a_walk_len: assert property (
    log_dev ##1 (!log_dev && !i_st_done) [*8] |-> o_sum_busy)
    else $error("checksum walk ended early");

  // return status
  a_rs_good: assert property (
    rs_hit && !rs_bad && !i_threshold_exceeded
    |=> o_rs_done && !o_command_abort_flag && o_cyl_low == 8'h4F && o_cyl_high == 8'hC2)
    else $error("good status signature wrong");
  a_rs_bad: assert property (
    rs_hit && !rs_bad && i_threshold_exceeded
    |=> o_rs_done && o_cyl_low == 8'hF4 && o_cyl_high == 8'h2C)
    else $error("exceeded signature wrong");
  a_rs_abort: assert property (
    rs_hit && (!i_health_enabled || i_cyl_high != 8'hC2) |=> o_rs_done && o_command_abort_flag)
    else $error("bad return-status not aborted");
  a_rs_quiet: assert property (
    !rs_hit |=> !o_rs_done)
    else $error("completion without a command");
  a_rs_keep: assert property (
    !rs_hit |=> $stable(o_cyl_low) && $stable(o_cyl_high))
    else $error("cylinder outputs moved without a command");
  a_rs_abort_keep: assert property (
    rs_hit && rs_bad |=> $stable(o_cyl_low) && $stable(o_cyl_high))
    else $error("aborted command changed cylinder outputs");
  a_rs_packet: assert property (
    rs_hit && i_packet_set |=> o_rs_done && o_command_abort_flag)
    else $error("packet device answered return-status");
  a_rs_cyl_lo: assert property (
    rs_hit && i_cyl_low != 8'h4F |=> o_rs_done && o_command_abort_flag)
    else $error("bad cylinder low not aborted");
  a_rs_other_dev: assert property (
    i_cmd_wr && i_device_select_bit != i_own_device |=> !o_rs_done)
    else $error("other device's command answered");
  a_rs_other_feat: assert property (
    i_cmd_wr && i_features != 8'hDA |=> !o_rs_done)
    else $error("other subcommand answered");
  a_cyl_legal: assert property (
    (o_cyl_low == 8'h4F && o_cyl_high == 8'hC2) || (o_cyl_low == 8'hF4 && o_cyl_high == 8'h2C))
    else $error("cylinder outputs hold no signature");

  c_rs_exceeded: cover property (rs_hit && !rs_bad && i_threshold_exceeded);
  c_rs_abort: cover property (rs_hit && rs_bad);
  c_st_wrap: cover property (i_st_done && r.st_idx == 5'h15);
  c_cnt_full: cover property (log_dev && r.err_cnt == CNT_MAX);
  c_walk_done: cover property ($fell(o_sum_busy));

endmodule : hls_builder
`default_nettype wire

// [testbench/hls_host.sv]
// host model: writes the return-status command through the task-file lines
// assumes the bench calls issue() and drives the device status levels
`timescale 1ns/10ps
`default_nettype none
module hls_host
  import hls_pkg::*;
(
  // clock
  input  wire logic       i_clock,
  // task-file command lines
  output var logic        o_cmd_wr,
  output var logic [7:0]  o_command,
  output var logic [7:0]  o_features,
  output var logic [7:0]  o_cyl_low,
  output var logic [7:0]  o_cyl_high,
  output var logic        o_device_select_bit
);
  initial {o_cmd_wr, o_command, o_features, o_cyl_low, o_cyl_high, o_device_select_bit} = '0;
  task automatic issue(input logic [7:0] f, cl, ch, input logic dev);
    @(negedge i_clock);
    {o_features, o_cyl_low, o_cyl_high} = {f, cl, ch};
    o_device_select_bit = dev;
    o_command = OP_HEALTH;
    o_cmd_wr = 1'b1;
    @(negedge i_clock);
    o_cmd_wr = 1'b0;
    // lines are not held after the write; invert so stale values cannot match
    {o_command, o_features} = ~{o_command, o_features};
    {o_cyl_low, o_cyl_high} = ~{o_cyl_low, o_cyl_high};
  endtask : issue
endmodule : hls_host
`default_nettype wire

// [testbench/tb_top.sv]
// bench for the health log sector builder: logs, checksums, return status
// assumes hls_host drives the command lines and one 50 MHz clock
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import hls_pkg::*;
  logic i_clock = 1'b0, i_rst_n = 1'b0, i_err_log = 1'b0, i_err_device_caused = 1'b0;
  logic i_err_hw_reset = 1'b0, i_st_issue = 1'b0, i_st_done = 1'b0, i_rd_req = 1'b0;
  logic i_rd_sel = 1'b0, i_own_device = 1'b1, i_health_enabled = 1'b1, i_packet_set = 1'b0;
  logic i_threshold_exceeded = 1'b0, i_cmd_wr, i_device_select_bit;
  logic o_rd_valid, o_sum_busy, o_rs_done, o_command_abort_flag;
  logic [55:0] i_err_taskfile = '0;
  logic [31:0] i_st_lba = '0;
  logic [15:0] i_hours = '0;
  logic [8:0]  i_rd_addr = '0;
  logic [3:0]  i_err_state = '0;
  logic [7:0]  i_st_sector = '0, i_st_status = '0, i_st_checkpoint = '0;
  logic [7:0]  i_command, i_features, i_cyl_low, i_cyl_high, o_rd_data, o_cyl_low, o_cyl_high;
  logic [7:0]  rd_val, elo = CYL_LO_OK, ehi = CYL_HI_OK;
  logic [27:0] cs [9] = '{28'hDA4FC2C, 28'hDA4FC2D, 28'hDA00C2C, 28'hDA4F00C, 28'hDA4FC28,
                          28'hDA4FC2E, 28'hD34FC2C, 28'hDA4FC24, 28'hDA4FC2C};
  int error_cnt = 0, comparisons = 0;
  always #10 i_clock = ~i_clock;
  hls_builder dut (.*);
  hls_host host (.i_clock, .o_cmd_wr(i_cmd_wr), .o_command(i_command), .o_features(i_features),
                 .o_cyl_low(i_cyl_low), .o_cyl_high(i_cyl_high),
                 .o_device_select_bit(i_device_select_bit));
  task automatic tally_and_finish();
    if (error_cnt == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [7:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic sel, input int a);
    @(negedge i_clock);
    {i_rd_req, i_rd_sel, i_rd_addr} = {1'b1, sel, 9'(a)};
    @(negedge i_clock);
    i_rd_req = 1'b0;
    rd_val = o_rd_data;
    chk({7'h0, o_rd_valid}, 8'h01);
  endtask : rd
  task automatic rc(input logic sel, input int a, input logic [7:0] exp);
    rd(sel, a);
    chk(rd_val, exp);
  endtask : rc
  task automatic sumchk(input logic sel);
    logic [7:0] s;
    s = 8'h00;
    for (int w = 0; o_sum_busy !== 1'b0; w++) begin
      if (w > 1100) begin
        error_cnt++;
        $display("MISMATCH t=%0t checksum walk hung", $time);
        tally_and_finish();
      end
      @(negedge i_clock);
    end
    for (int a = 0; a < 512; a++) begin
      rd(sel, a);
      s += rd_val;
    end
    chk(s, 8'h00);
  endtask : sumchk
  task automatic err(input logic dc, hw, input logic [55:0] tf, input logic [3:0] st,
                     input logic [15:0] hr);
    @(negedge i_clock);
    {i_err_device_caused, i_err_hw_reset, i_err_taskfile} = {dc, hw, tf};
    {i_err_state, i_hours} = {st, hr};
    i_err_log = 1'b1;
    @(negedge i_clock);
    i_err_log = 1'b0;
  endtask : err
  task automatic t_reset();
    rc(0, 1, 8'h00);
    rc(0, 511, 8'hFF);
    rc(1, 0, 8'h01);
    rc(1, 1, 8'h00);
    rc(1, 508, 8'h00);
    rc(1, 26, 8'h00);
    rc(1, 511, 8'hFF);
  endtask : t_reset
  task automatic t_errlog();
    err(1'b0, 1'b0, 56'h11223344556677, 4'h3, 16'h1234);
    rc(0, 1, 8'h00);
    rc(0, 452, 8'h00);
    err(1'b1, 1'b0, 56'h37363534333231, 4'h3, 16'hABCD);
    for (int i = 0; i < 7; i++) rc(0, 63 + i, 8'(8'h31 + i));
    rc(0, 70, 8'h00);
    rc(0, 89, 8'h03);
    rc(0, 90, 8'hCD);
    rc(0, 91, 8'hAB);
    rc(0, 452, 8'h01);
    rc(0, 453, 8'h00);
    sumchk(0);
    err(1'b1, 1'b1, 56'hFFEEDDCCBBAA99, 4'h4, 16'h0102);
    for (int i = 0; i < 7; i++) rc(0, 153 + i, 8'h00);
    rc(0, 179, 8'h04);
    rc(0, 180, 8'h02);
    rc(0, 452, 8'h02);
  endtask : t_errlog
  task automatic t_states();
    // two records already logged, so the s-th lands in slot (s+2) mod 5
    for (int s = 0; s < 16; s++) begin
      err(1'b1, 1'b0, 56'h0, 4'(s), 16'h0000);
      rc(0, 89 + 90 * ((s + 2) % 5), 8'(s));
      rc(0, 1, 8'((s + 2) % 5 + 1));
    end
  endtask : t_states
  task automatic st(input int k);
    @(negedge i_clock);
    {i_st_issue, i_st_sector} = {1'b1, 8'(k)};
    @(negedge i_clock);
    i_st_issue = 1'b0;
    {i_st_status, i_hours, i_st_checkpoint} = {8'(8'h40 + k), 16'(16'h0300 + k), 8'(8'h80 + k)};
    i_st_lba = 32'hC3B2A100 + 32'(k);
    i_st_done = 1'b1;
    @(negedge i_clock);
    i_st_done = 1'b0;
  endtask : st
  task automatic desc(input int slot, k);
    int b;
    logic [31:0] lba;
    b = 2 + 24 * (slot - 1);
    lba = 32'hC3B2A100 + 32'(k);
    rc(1, b, 8'(k));
    rc(1, b + 1, 8'(8'h40 + k));
    rc(1, b + 2, 8'(k));
    rc(1, b + 3, 8'h03);
    rc(1, b + 4, 8'(8'h80 + k));
    for (int j = 0; j < 4; j++) rc(1, b + 5 + j, lba[8*j+:8]);
  endtask : desc
  task automatic t_selftest();
    for (int k = 1; k <= 22; k++) begin
      st(k);
      rc(1, 508, 8'((k - 1) % 21 + 1));
      if (k == 1) rc(1, 26, 8'h00);
    end
    desc(1, 22);
    desc(2, 2);
    desc(21, 21);
    sumchk(1);
  endtask : t_selftest
  task automatic t_status();
    logic [7:0] f, cl, ch;
    logic dev, ok, ab;
    for (int i = 0; i < 9; i++) begin
      {f, cl, ch, dev, i_health_enabled, i_packet_set, i_threshold_exceeded} = cs[i];
      ok = f == FEAT_STATUS && dev == i_own_device;
      ab = !i_health_enabled || i_packet_set || cl != CYL_LO_OK || ch != CYL_HI_OK;
      if (ok && !ab) begin
        {elo, ehi} = i_threshold_exceeded ? {CYL_LO_BAD, CYL_HI_BAD}
                                          : {CYL_LO_OK, CYL_HI_OK};
      end
      host.issue(f, cl, ch, dev);
      chk({7'h0, o_rs_done}, {7'h0, ok});
      if (ok) chk({7'h0, o_command_abort_flag}, {7'h0, ab});
      chk(o_cyl_low, elo);
      chk(o_cyl_high, ehi);
      @(negedge i_clock);
      chk({7'h0, o_rs_done}, 8'h00);
    end
  endtask : t_status
  task automatic t_satur();
    // 18 errors so far; a held event offers one error per clock
    @(negedge i_clock);
    {i_err_device_caused, i_err_hw_reset, i_err_log} = 3'b101;
    repeat (65535) @(negedge i_clock);
    i_err_log = 1'b0;
    rc(0, 452, 8'hFF);
    err(1'b1, 1'b0, 56'h0, 4'h3, 16'h0000);
    rc(0, 452, 8'hFF);
    rc(0, 453, 8'hFF);
    sumchk(0);
  endtask : t_satur
  task automatic t_midreset();
    // leave the exceeded signature and a full count behind, then reset mid-run
    i_threshold_exceeded = 1'b1;
    host.issue(FEAT_STATUS, CYL_LO_OK, CYL_HI_OK, i_own_device);
    chk(o_cyl_low, CYL_LO_BAD);
    @(negedge i_clock);
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_clock);
    chk({7'h0, o_sum_busy}, 8'h00);
    chk({7'h0, o_command_abort_flag}, 8'h00);
    chk(o_cyl_low, CYL_LO_OK);
    chk(o_cyl_high, CYL_HI_OK);
    i_rst_n = 1'b1;
    rc(0, 452, 8'h00);
    rc(0, 1, 8'h00);
    rc(0, 511, 8'hFF);
    rc(1, 508, 8'h00);
    rc(1, 2, 8'h00);
    rc(1, 511, 8'hFF);
  endtask : t_midreset
  initial begin
    repeat (12) @(negedge i_clock);
    i_rst_n = 1'b1;
    t_reset();
    t_errlog();
    t_states();
    t_selftest();
    t_status();
    t_satur();
    t_midreset();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
